// ==== rtl/nhbi_fifo.sv ====
// synchronous fifo with valid/ready on both sides and registered full flag
`timescale 1ns/1ps
module nhbi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             sys_clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W+1)'(DEPTH);
	localparam logic [PTR_W:0] ONE_CNT   = (PTR_W+1)'(1);
	localparam logic [PTR_W-1:0] ONE_PTR = PTR_W'(1);
	localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr_reg;
	logic [PTR_W-1:0] rd_ptr_reg;
	logic [PTR_W:0]   count_reg;
	logic             full_reg;
	logic             push;
	logic             pop;
	logic [PTR_W:0]   count_next;

	function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
		return (p == LAST_PTR) ? '0 : p + ONE_PTR;
	endfunction

	assign push          = in_valid_in & ~full_reg;
	assign pop           = out_ready_in & (count_reg != '0);
	assign in_ready_out  = ~full_reg;
	assign out_valid_out = (count_reg != '0);
	assign out_data_out  = mem[rd_ptr_reg];

	always_comb begin
		count_next = count_reg;
		if (push & ~pop) begin
			count_next = count_reg + ONE_CNT;
		end else if (pop & ~push) begin
			count_next = count_reg - ONE_CNT;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			full_reg   <= 1'b0;
		end else begin
			if (push) begin
				mem[wr_ptr_reg] <= in_data_in;
				wr_ptr_reg      <= bump(wr_ptr_reg);
			end
			if (pop) begin
				rd_ptr_reg <= bump(rd_ptr_reg);
			end
			count_reg <= count_next;
			full_reg  <= (count_next == DEPTH_CNT);
		end
	end
endmodule // nhbi_fifo

// ==== rtl/nhbi_host_bus.sv ====
// host bus interface: slave register port and dma master memory cycles
//
// What this block does
// - slave register data on low eight lines
// - upper eight lines float during slave access
// - master drives sixteen address bits in t1
// - word mode carries sixteen data bits t2-t4
// - byte mode holds address high during t2-t4
// - master strobes show dma transfer direction
// - index captured on address strobe falling edge
// - index latch transparent while strobe high
// - address strobe driven out as master
// - chip select enters slave mode, index selects
// - write strobe low in t2, t3, wait
// - write data valid at write strobe rise
// - master strobes floating until bus grant
// - read strobe low in t2, t3, wait
// - register write taken on write strobe rise
// - register data driven two clocks after read strobe falls
// - access grant held off until synchronized
// - dma cycle four bus clocks plus wait
`timescale 1ns/1ps
module nhbi_host_bus
	import nhbi_pkg::*;
(
	input  wire logic                       sys_clk_in,
	input  wire logic                       rst_n_in,
	input  wire logic [nhbi_pkg::ADDR_W-1:0] muxed_addr_data_bus_in,
	output logic [nhbi_pkg::ADDR_W-1:0]      muxed_addr_data_bus_out,
	output logic                            muxed_addr_data_bus_lo_oe_n_out,
	output logic                            muxed_addr_data_bus_hi_oe_n_out,
	input  wire logic                       address_strobe_low_in,
	output logic                            address_strobe_low_out,
	output logic                            address_strobe_low_oe_n_out,
	input  wire logic [nhbi_pkg::IDX_W-1:0]  register_index_lines_in,
	input  wire logic                       chip_select_n_in,
	input  wire logic                       slave_read_strobe_n_in,
	input  wire logic                       slave_write_strobe_n_in,
	output logic                            access_grant_n_out,
	output logic                            master_write_strobe_n_out,
	output logic                            master_read_strobe_n_out,
	output logic                            master_strobe_oe_n_out,
	input  wire logic                       bus_grant_in,
	output logic                            bus_req_out,
	input  wire logic                       dma_bus_clock_in,
	input  wire logic                       wait_request_in,
	input  wire logic                       dma_cmd_valid_in,
	output logic                            dma_cmd_ready_out,
	input  wire logic                       dma_cmd_write_in,
	input  wire logic                       dma_cmd_byte_in,
	input  wire logic [nhbi_pkg::ADDR_W-1:0] dma_cmd_addr_in,
	input  wire logic [nhbi_pkg::DATA_W-1:0] dma_cmd_data_in,
	output logic [nhbi_pkg::DATA_W-1:0]      dma_rd_data_out,
	output logic                            dma_rd_valid_out,
	output logic                            reg_wr_pulse_out,
	output logic [nhbi_pkg::IDX_W-1:0]       reg_wr_index_out,
	output logic [nhbi_pkg::BYTE_W-1:0]      reg_wr_data_out
);
	import nhbi_pkg::*;

	typedef struct packed {
		nhbi_mst_e         mst;
		nhbi_slv_e         slv;
		logic              dma_bus_clock_prev;
		logic              srd_prev;
		logic              swr_prev;
		logic [IDX_W-1:0]  idx;
		logic [ADDR_W-1:0] ad_out;
		logic              ad_lo_oe_n;
		logic              ad_hi_oe_n;
		logic              ads_out;
		logic              ads_oe_n;
		logic              ack_n;
		logic              mwr_n;
		logic              mrd_n;
		logic              strb_oe_n;
		logic              bus_req;
		logic              cmd_wr;
		logic              cmd_byte;
		logic [ADDR_W-1:0] cmd_addr;
		logic [DATA_W-1:0] cmd_data;
		logic [DATA_W-1:0] rd_data;
		logic              rd_valid;
		logic              wr_pulse;
		logic [IDX_W-1:0]  wr_idx;
		logic [BYTE_W-1:0] wr_data;
	} nhbi_state_s;

	localparam nhbi_state_s ST_RESET = '{
		mst: MST_IDLE, slv: SLV_IDLE,
		dma_bus_clock_prev: 1'b0, srd_prev: 1'b1, swr_prev: 1'b1,
		idx: RESET_IDX, ad_out: RESET_WORD,
		ad_lo_oe_n: 1'b1, ad_hi_oe_n: 1'b1,
		ads_out: 1'b0, ads_oe_n: 1'b1, ack_n: 1'b1,
		mwr_n: 1'b1, mrd_n: 1'b1, strb_oe_n: 1'b1, bus_req: 1'b0,
		cmd_wr: 1'b0, cmd_byte: 1'b0, cmd_addr: RESET_WORD, cmd_data: RESET_WORD,
		rd_data: RESET_WORD, rd_valid: 1'b0,
		wr_pulse: 1'b0, wr_idx: RESET_IDX, wr_data: RESET_BYTE
	};

	nhbi_state_s       st_reg;
	nhbi_state_s       st_next;
	logic [CMD_W-1:0]  fifo_in_data;
	logic [CMD_W-1:0]  fifo_out_data;
	logic              fifo_out_valid;
	logic              fifo_pop;
	logic              fifo_in_ready;
	logic              mem_we;
	logic [IDX_W-1:0]  mem_raddr;
	logic [BYTE_W-1:0] mem_rdata;
	logic              dma_bus_clock_rise;
	logic              dma_active;
	logic              slave_sel;
	logic              swr_rise;

	function automatic logic rose(input logic prev, input logic cur);
		return ~prev & cur;
	endfunction

	function automatic logic fell(input logic prev, input logic cur);
		return prev & ~cur;
	endfunction

	// launch t1 of a memory cycle from the head of the command fifo
	function automatic nhbi_state_s start_cycle(input nhbi_state_s s,
			input logic [CMD_W-1:0] cmd);
		nhbi_state_s o;
		o            = s;
		o.mst        = MST_T1;
		o.cmd_wr     = cmd[CMD_WR_BIT];
		o.cmd_byte   = cmd[CMD_BYTE_BIT];
		o.cmd_addr   = cmd[CMD_ADDR_LSB +: ADDR_W];
		o.cmd_data   = cmd[CMD_DATA_LSB +: DATA_W];
		o.ad_out     = cmd[CMD_ADDR_LSB +: ADDR_W];
		o.ad_lo_oe_n = 1'b0;
		o.ad_hi_oe_n = 1'b0;
		o.ads_out    = 1'b1;
		o.ads_oe_n   = 1'b0;
		o.mwr_n      = 1'b1;
		o.mrd_n      = 1'b1;
		return o;
	endfunction

	assign fifo_in_data = {dma_cmd_write_in, dma_cmd_byte_in, dma_cmd_addr_in, dma_cmd_data_in};

	nhbi_fifo #(
		.WIDTH(CMD_W),
		.DEPTH(FIFO_DEPTH)
	) u_cmd_fifo (
		.sys_clk_in   (sys_clk_in),
		.rst_n_in     (rst_n_in),
		.in_valid_in  (dma_cmd_valid_in),
		.in_ready_out (fifo_in_ready),
		.in_data_in   (fifo_in_data),
		.out_valid_out(fifo_out_valid),
		.out_ready_in (fifo_pop),
		.out_data_out (fifo_out_data)
	);

	nhbi_regmem u_regs (
		.sys_clk_in (sys_clk_in),
		.rst_n_in   (rst_n_in),
		.wr_en_in   (mem_we),
		.wr_idx_in  (st_reg.idx),
		.wr_data_in (muxed_addr_data_bus_in[BYTE_W-1:0]),
		.rd_idx_in  (mem_raddr),
		.rd_data_out(mem_rdata)
	);

	always_comb begin
		st_next  = st_reg;
		fifo_pop = 1'b0;

		st_next.rd_valid  = 1'b0;
		st_next.wr_pulse  = 1'b0;
		st_next.dma_bus_clock_prev = dma_bus_clock_in;
		st_next.srd_prev  = slave_read_strobe_n_in;
		st_next.swr_prev  = slave_write_strobe_n_in;
		st_next.bus_req   = fifo_out_valid;
		st_next.strb_oe_n = ~bus_grant_in;

		dma_bus_clock_rise  = rose(st_reg.dma_bus_clock_prev, dma_bus_clock_in);
		swr_rise   = rose(st_reg.swr_prev, slave_write_strobe_n_in);
		dma_active = st_reg.bus_req | (st_reg.mst != MST_IDLE);
		slave_sel  = ~dma_active & ~chip_select_n_in;

		// the latch follows the lines while the strobe is high and keeps the
		// last value seen before the fall
		mem_raddr = address_strobe_low_in ? register_index_lines_in : st_reg.idx;
		if (slave_sel & address_strobe_low_in) begin
			st_next.idx = register_index_lines_in;
		end

		mem_we = 1'b0;

		if (!dma_active) begin
			st_next.ad_hi_oe_n = 1'b1;
			st_next.ads_oe_n   = 1'b1;
			st_next.ads_out    = 1'b0;
			case (st_reg.slv)
				SLV_IDLE: begin
					st_next.ad_lo_oe_n = 1'b1;
					st_next.ack_n      = 1'b1;
					if (slave_sel & fell(st_reg.srd_prev, slave_read_strobe_n_in)) begin
						st_next.slv = SLV_RD_WAIT;
					end else if (slave_sel & fell(st_reg.swr_prev, slave_write_strobe_n_in)) begin
						st_next.slv   = SLV_WR;
						st_next.ack_n = 1'b0;
					end
				end
				SLV_RD_WAIT: begin
					// store read data lands one clock after the strobe fall,
					// so access grant waits for it
					st_next.ad_out     = {RESET_BYTE, mem_rdata};
					st_next.ad_lo_oe_n = 1'b0;
					st_next.ack_n      = 1'b0;
					st_next.slv        = SLV_RD;
				end
				SLV_RD: begin
					if (slave_read_strobe_n_in | chip_select_n_in) begin
						st_next.ad_lo_oe_n = 1'b1;
						st_next.ack_n      = 1'b1;
						st_next.slv        = SLV_IDLE;
					end
				end
				SLV_WR: begin
					if (swr_rise) begin
						mem_we           = 1'b1;
						st_next.wr_pulse = 1'b1;
						st_next.wr_idx   = st_reg.idx;
						st_next.wr_data  = muxed_addr_data_bus_in[BYTE_W-1:0];
						st_next.ack_n    = 1'b1;
						st_next.slv      = SLV_IDLE;
					end else if (chip_select_n_in) begin
						// cycle abandoned without a strobe rise: nothing written
						st_next.ack_n = 1'b1;
						st_next.slv   = SLV_IDLE;
					end
				end
				default: begin
					st_next.slv = SLV_IDLE;
				end
			endcase
		end else begin
			// a dma request pending locks out slave accesses until it drains
			st_next.slv   = SLV_IDLE;
			st_next.ack_n = 1'b1;
		end

		case (st_reg.mst)
			MST_IDLE: begin
				if (dma_bus_clock_rise & bus_grant_in & fifo_out_valid) begin
					st_next  = start_cycle(st_next, fifo_out_data);
					fifo_pop = 1'b1;
				end else if (st_reg.bus_req) begin
					st_next.ad_lo_oe_n = 1'b1;
					st_next.ad_hi_oe_n = 1'b1;
					st_next.ads_oe_n   = 1'b1;
				end
			end
			MST_T1: begin
				if (dma_bus_clock_rise) begin
					st_next.mst     = MST_T2;
					st_next.ads_out = 1'b0;
					st_next.mwr_n   = ~st_reg.cmd_wr;
					st_next.mrd_n   = st_reg.cmd_wr;
					if (st_reg.cmd_byte) begin
						st_next.ad_out     = {st_reg.cmd_addr[ADDR_W-1:BYTE_W],
						                      st_reg.cmd_data[BYTE_W-1:0]};
						st_next.ad_hi_oe_n = 1'b0;
						st_next.ad_lo_oe_n = ~st_reg.cmd_wr;
					end else begin
						st_next.ad_out     = st_reg.cmd_data;
						st_next.ad_hi_oe_n = ~st_reg.cmd_wr;
						st_next.ad_lo_oe_n = ~st_reg.cmd_wr;
					end
				end
			end
			MST_T2: begin
				if (dma_bus_clock_rise) begin
					st_next.mst = MST_T3;
				end
			end
			MST_T3: begin
				if (dma_bus_clock_rise) begin
					// wait request is looked at only here, and buys one extra clock
					st_next.mst = wait_request_in ? MST_TW : MST_T4;
					if (!wait_request_in) begin
						st_next.mwr_n = 1'b1;
						st_next.mrd_n = 1'b1;
						if (!st_reg.cmd_wr) begin
							st_next.rd_valid = 1'b1;
							st_next.rd_data  = st_reg.cmd_byte ?
								{RESET_BYTE, muxed_addr_data_bus_in[BYTE_W-1:0]} :
								muxed_addr_data_bus_in;
						end
					end
				end
			end
			MST_TW: begin
				if (dma_bus_clock_rise) begin
					st_next.mst   = MST_T4;
					st_next.mwr_n = 1'b1;
					st_next.mrd_n = 1'b1;
					if (!st_reg.cmd_wr) begin
						st_next.rd_valid = 1'b1;
						st_next.rd_data  = st_reg.cmd_byte ?
							{RESET_BYTE, muxed_addr_data_bus_in[BYTE_W-1:0]} :
							muxed_addr_data_bus_in;
					end
				end
			end
			MST_T4: begin
				// write data stays on the lines through t4, past the strobe rise
				if (dma_bus_clock_rise) begin
					if (bus_grant_in & fifo_out_valid) begin
						st_next  = start_cycle(st_next, fifo_out_data);
						fifo_pop = 1'b1;
					end else begin
						st_next.mst        = MST_IDLE;
						st_next.ad_lo_oe_n = 1'b1;
						st_next.ad_hi_oe_n = 1'b1;
						st_next.ads_oe_n   = 1'b1;
					end
				end
			end
			default: begin
				st_next.mst = MST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			st_reg <= ST_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign muxed_addr_data_bus_out         = st_reg.ad_out;
	assign muxed_addr_data_bus_lo_oe_n_out = st_reg.ad_lo_oe_n;
	assign muxed_addr_data_bus_hi_oe_n_out = st_reg.ad_hi_oe_n;
	assign address_strobe_low_out          = st_reg.ads_out;
	assign address_strobe_low_oe_n_out     = st_reg.ads_oe_n;
	assign access_grant_n_out              = st_reg.ack_n;
	assign master_write_strobe_n_out       = st_reg.mwr_n;
	assign master_read_strobe_n_out        = st_reg.mrd_n;
	assign master_strobe_oe_n_out          = st_reg.strb_oe_n;
	assign bus_req_out                     = st_reg.bus_req;
	assign dma_cmd_ready_out               = fifo_in_ready;
	assign dma_rd_data_out                 = st_reg.rd_data;
	assign dma_rd_valid_out                = st_reg.rd_valid;
	assign reg_wr_pulse_out                = st_reg.wr_pulse;
	assign reg_wr_index_out                = st_reg.wr_idx;
	assign reg_wr_data_out                 = st_reg.wr_data;
endmodule // nhbi_host_bus

// ==== rtl/nhbi_pkg.sv ====
// shared constants, field layouts and state encodings of the host bus interface
package nhbi_pkg;
	localparam int ADDR_W     = 16;
	localparam int DATA_W     = 16;
	localparam int BYTE_W     = 8;
	localparam int IDX_W      = 4;
	localparam int REG_COUNT  = 16;
	localparam int FIFO_DEPTH = 32;

	// dma command word: {write, byte_mode, address, data}
	localparam int CMD_DATA_LSB = 0;
	localparam int CMD_ADDR_LSB = CMD_DATA_LSB + DATA_W;
	localparam int CMD_BYTE_BIT = CMD_ADDR_LSB + ADDR_W;
	localparam int CMD_WR_BIT   = CMD_BYTE_BIT + 1;
	localparam int CMD_W        = CMD_WR_BIT + 1;

	localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;
	localparam logic [BYTE_W-1:0] RESET_BYTE = 8'h00;
	localparam logic [IDX_W-1:0]  RESET_IDX  = 4'h0;

	typedef enum logic [2:0] {
		MST_IDLE = 3'h0,
		MST_T1   = 3'h1,
		MST_T2   = 3'h2,
		MST_T3   = 3'h3,
		MST_TW   = 3'h4,
		MST_T4   = 3'h5
	} nhbi_mst_e;

	typedef enum logic [1:0] {
		SLV_IDLE    = 2'h0,
		SLV_RD_WAIT = 2'h1,
		SLV_RD      = 2'h2,
		SLV_WR      = 2'h3
	} nhbi_slv_e;
endpackage

// ==== rtl/nhbi_regmem.sv ====
// small register store behind the slave port, read data registered
`timescale 1ns/1ps
module nhbi_regmem
	import nhbi_pkg::*;
(
	input  wire logic              sys_clk_in,
	input  wire logic              rst_n_in,
	input  wire logic              wr_en_in,
	input  wire logic [IDX_W-1:0]  wr_idx_in,
	input  wire logic [BYTE_W-1:0] wr_data_in,
	input  wire logic [IDX_W-1:0]  rd_idx_in,
	output logic [BYTE_W-1:0]      rd_data_out
);
	logic [BYTE_W-1:0] regs [REG_COUNT];

	always_ff @(posedge sys_clk_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regs[i] <= RESET_BYTE;
			end
			rd_data_out <= RESET_BYTE;
		end else begin
			if (wr_en_in) begin
				regs[wr_idx_in] <= wr_data_in;
			end
			rd_data_out <= regs[rd_idx_in];
		end
	end
endmodule // nhbi_regmem

// ==== tb/nhbi_host_bus_monitor.sv ====
// port-level assertions for the host bus interface
`timescale 1ns/1ps
module nhbi_host_bus_monitor (
	input wire logic        sys_clk_in,
	input wire logic        rst_n_in,
	input wire logic [15:0] muxed_addr_data_bus_in,
	input wire logic [15:0] muxed_addr_data_bus_out,
	input wire logic        muxed_addr_data_bus_lo_oe_n_out,
	input wire logic        muxed_addr_data_bus_hi_oe_n_out,
	input wire logic        address_strobe_low_out,
	input wire logic        address_strobe_low_oe_n_out,
	input wire logic        chip_select_n_in,
	input wire logic        slave_read_strobe_n_in,
	input wire logic        slave_write_strobe_n_in,
	input wire logic        access_grant_n_out,
	input wire logic        master_write_strobe_n_out,
	input wire logic        master_read_strobe_n_out,
	input wire logic        master_strobe_oe_n_out,
	input wire logic        bus_grant_in,
	input wire logic        bus_req_out,
	input wire logic        dma_rd_valid_out,
	input wire logic        reg_wr_pulse_out,
	input wire logic [7:0]  reg_wr_data_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	logic idle;
	assign idle = !chip_select_n_in && !bus_req_out && master_read_strobe_n_out
		&& master_write_strobe_n_out && address_strobe_low_oe_n_out;
	strobe_float_a: assert property (!$past(bus_grant_in) |-> master_strobe_oe_n_out)
		else $error("master strobes driven without grant");
	hi_float_a: assert property (!access_grant_n_out |-> muxed_addr_data_bus_hi_oe_n_out)
		else $error("upper lines driven in slave access");
	addr_phase_a: assert property (address_strobe_low_out |-> !address_strobe_low_oe_n_out
		&& !muxed_addr_data_bus_lo_oe_n_out && !muxed_addr_data_bus_hi_oe_n_out)
		else $error("address phase not driven on all lines");
	strobe_next_a: assert property ($fell(address_strobe_low_out) |->
		!master_write_strobe_n_out || !master_read_strobe_n_out)
		else $error("no transfer strobe after address phase");
	wr_drive_a: assert property (!master_write_strobe_n_out |->
		!muxed_addr_data_bus_lo_oe_n_out && !muxed_addr_data_bus_hi_oe_n_out)
		else $error("write strobe low without data driven");
	wr_hold_a: assert property ($rose(master_write_strobe_n_out) |->
		$stable(muxed_addr_data_bus_out) && !muxed_addr_data_bus_lo_oe_n_out)
		else $error("write data not held at strobe rise");
	rd_release_a: assert property (!master_read_strobe_n_out |-> muxed_addr_data_bus_lo_oe_n_out)
		else $error("low lines driven during memory read");
	one_dir_a: assert property (!(!master_read_strobe_n_out && !master_write_strobe_n_out))
		else $error("both master strobes low");
	rd_capture_a: assert property (dma_rd_valid_out |->
		master_read_strobe_n_out && !$past(master_read_strobe_n_out))
		else $error("read data reported off strobe rise");
	wr_grant_a: assert property (idle && $fell(slave_write_strobe_n_in) |-> ##1 !access_grant_n_out)
		else $error("write grant late");
	rd_answer_a: assert property (idle && $fell(slave_read_strobe_n_in) |->
		##2 (!muxed_addr_data_bus_lo_oe_n_out && !access_grant_n_out))
		else $error("read data not driven in time");
	wr_take_a: assert property (reg_wr_pulse_out |-> $past(slave_write_strobe_n_in)
		&& !$past(slave_write_strobe_n_in, 2)
		&& {8'h00, reg_wr_data_out} == ($past(muxed_addr_data_bus_in) & 16'h00FF))
		else $error("register write not taken at strobe rise");
endmodule // nhbi_host_bus_monitor
bind nhbi_host_bus nhbi_host_bus_monitor mon_i (.*);

// ==== tb/nhbi_host_bus_test.sv ====
// self-checking bench: slave register port and dma memory cycles against a reference
`timescale 1ns/1ps
module nhbi_host_bus_test;
	import nhbi_pkg::*;
	logic sys_clk_in = 0, rst_n_in = 0, cpu_ads = 1, cpu_en = 0, slow = 0;
	logic chip_select_n_in = 1, slave_read_strobe_n_in = 1, slave_write_strobe_n_in = 1;
	logic bus_grant_in = 0, dma_bus_clock_in = 0, dma_cmd_valid_in = 0;
	logic dma_cmd_write_in = 0, dma_cmd_byte_in = 0;
	logic [15:0] dma_cmd_addr_in = 0, dma_cmd_data_in = 0, muxed_addr_data_bus_out, mem_d;
	logic [15:0] dma_rd_data_out;
	logic [7:0]  cpu_d = 0, cyc = 0, reg_wr_data_out, exp_reg [16];
	logic [3:0]  register_index_lines_in = 0, reg_wr_index_out;
	logic muxed_addr_data_bus_lo_oe_n_out, muxed_addr_data_bus_hi_oe_n_out, mem_drv;
	logic address_strobe_low_out, address_strobe_low_oe_n_out, access_grant_n_out;
	logic master_write_strobe_n_out, master_read_strobe_n_out, master_strobe_oe_n_out;
	logic bus_req_out, wait_request_in, dma_cmd_ready_out, dma_rd_valid_out, reg_wr_pulse_out;
	wire [15:0]  muxed_addr_data_bus_in;
	wire         address_strobe_low_in;
	logic [15:0] exp_mem [logic [15:0]];
	logic [15:0] rdq [$];
	logic [11:0] wrq [$];
	int err_total = 0, samples_checked = 0, i;
	integer seed = 32'h0996ED86;
	logic [15:0] base;
	// undriven lines show a changing pattern rather than a stale value
	assign muxed_addr_data_bus_in[7:0] = !muxed_addr_data_bus_lo_oe_n_out ?
		muxed_addr_data_bus_out[7:0] : cpu_en ? cpu_d : mem_drv ? mem_d[7:0] : cyc;
	assign muxed_addr_data_bus_in[15:8] = !muxed_addr_data_bus_hi_oe_n_out ?
		muxed_addr_data_bus_out[15:8] : mem_drv ? mem_d[15:8] : ~cyc;
	assign address_strobe_low_in = !address_strobe_low_oe_n_out ? address_strobe_low_out : cpu_ads;
	nhbi_host_bus dut (.*);
	nhbi_mem_model mem_i (.clk_in(sys_clk_in), .bus_in(muxed_addr_data_bus_in),
		.ads_in(address_strobe_low_out), .ads_oe_n_in(address_strobe_low_oe_n_out),
		.mwr_n_in(master_write_strobe_n_out), .mrd_n_in(master_read_strobe_n_out),
		.slow_in(slow), .wait_out(wait_request_in), .drv_out(mem_drv), .data_out(mem_d));
	always #2 sys_clk_in = ~sys_clk_in;
	always @(negedge sys_clk_in) begin
		cyc <= cyc + 8'h01;
		if (cyc[1:0] == 2'h3) begin
			dma_bus_clock_in <= ~dma_bus_clock_in;
			slow <= 1'($random(seed));
		end
		if (dma_rd_valid_out === 1'b1)
			cmp_val(dma_rd_data_out, rdq.pop_front());
		if (reg_wr_pulse_out === 1'b1)
			cmp_val({4'h0, reg_wr_index_out, reg_wr_data_out}, {4'h0, wrq.pop_front()});
	end
	task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_flag(input logic got, input logic exp);
		cmp_val({15'h0000, got}, {15'h0000, exp});
	endtask
	task automatic wait_grant(input logic lvl);
		int n;
		n = 0;
		while (access_grant_n_out !== lvl && n < 20) begin
			@(negedge sys_clk_in);
			n++;
		end
		cmp_flag(access_grant_n_out, lvl);
	endtask
	task automatic reg_write(input logic [3:0] idx, input logic [7:0] d, input logic abort);
		@(negedge sys_clk_in);
		register_index_lines_in = idx;
		chip_select_n_in = 0;
		@(negedge sys_clk_in);
		cpu_ads = 0;
		@(negedge sys_clk_in);
		register_index_lines_in = ~idx;
		cpu_d = d;
		cpu_en = 1;
		slave_write_strobe_n_in = 0;
		wait_grant(0);
		chip_select_n_in = abort;
		// queued before the strobe rise: the report pulse follows it at once
		if (!abort) begin
			exp_reg[idx] = d;
			wrq.push_back({idx, d});
		end
		@(negedge sys_clk_in);
		slave_write_strobe_n_in = 1;
		repeat (3) @(negedge sys_clk_in);
		chip_select_n_in = 1;
		cpu_en = 0;
		cpu_ads = 1;
		wait_grant(1);
	endtask
	task automatic reg_read(input logic [3:0] idx);
		@(negedge sys_clk_in);
		register_index_lines_in = idx;
		chip_select_n_in = 0;
		@(negedge sys_clk_in);
		slave_read_strobe_n_in = 0;
		wait_grant(0);
		cmp_flag(muxed_addr_data_bus_lo_oe_n_out, 0);
		cmp_flag(muxed_addr_data_bus_hi_oe_n_out, 1);
		cmp_val({8'h00, muxed_addr_data_bus_in[7:0]}, {8'h00, exp_reg[idx]});
		slave_read_strobe_n_in = 1;
		chip_select_n_in = 1;
		wait_grant(1);
	endtask
	task automatic push(input logic w, input logic b, input logic [15:0] a, input logic [15:0] d);
		int n;
		n = 0;
		@(negedge sys_clk_in);
		{dma_cmd_write_in, dma_cmd_byte_in, dma_cmd_addr_in, dma_cmd_data_in} = {w, b, a, d};
		dma_cmd_valid_in = 1;
		while (dma_cmd_ready_out !== 1'b1 && n < 2000) begin
			@(negedge sys_clk_in);
			n++;
		end
		if (n >= 2000)
			err_total++;
		if (w)
			exp_mem[a] = b ? {a[15:8], d[7:0]} : d;
		else
			rdq.push_back(b ? {8'h00, exp_mem[a][7:0]} : exp_mem[a]);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		while ((bus_req_out !== 1'b0 || rdq.size() != 0) && n < 5000) begin
			@(negedge sys_clk_in);
			n++;
		end
		if (n >= 5000)
			err_total++;
		repeat (48) @(negedge sys_clk_in);
	endtask
	task automatic final_report;
		$display("checks=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		err_total++;
		final_report();
	end
	initial begin
		for (i = 0; i < 16; i++)
			exp_reg[i] = 8'h00;
		repeat (4) @(negedge sys_clk_in);
		rst_n_in = 1;
		@(negedge sys_clk_in);
		cmp_val({9'h000, muxed_addr_data_bus_lo_oe_n_out, muxed_addr_data_bus_hi_oe_n_out,
			address_strobe_low_oe_n_out, access_grant_n_out, master_strobe_oe_n_out,
			dma_cmd_ready_out, bus_req_out}, 16'h007E);
		reg_read(4'h3);
		for (i = 0; i < 16; i++)
			reg_write(i[3:0], 8'($random(seed)), 1'b0);
		reg_write(4'h5, ~exp_reg[5], 1'b1); // refused: select dropped early
		for (i = 0; i < 16; i++)
			reg_read(i[3:0]);
		$display("test slave done");
		// grant withheld so the command fifo fills and refuses
		base = 16'($random(seed));
		for (i = 0; i < 32; i++)
			push(1'b1, 1'($random(seed)), {base[15:5], i[4:0]}, 16'($random(seed)));
		@(negedge sys_clk_in);
		cmp_flag(dma_cmd_ready_out, 0);
		cmp_flag(master_strobe_oe_n_out, 1);
		dma_cmd_valid_in = 0;
		bus_grant_in = 1;
		wait_idle();
		for (i = 0; i < 32; i++)
			cmp_val(mem_i.mem[{base[15:5], i[4:0]}], exp_mem[{base[15:5], i[4:0]}]);
		$display("test dma write done");
		for (i = 0; i < 32; i++)
			push(1'b0, 1'($random(seed)), {base[15:5], i[4:0]}, 16'h0000);
		@(negedge sys_clk_in);
		dma_cmd_valid_in = 0;
		wait_idle();
		cmp_flag(rdq.size() == 0, 1);
		$display("test dma read done");
		reg_read(4'hA);
		$display("test slave after dma done");
		final_report();
	end
endmodule // nhbi_host_bus_test

// ==== tb/nhbi_mem_model.sv ====
// buffer memory partner on the dma side of the host bus
`timescale 1ns/1ps
module nhbi_mem_model (
	input  wire logic        clk_in,
	input  wire logic [15:0] bus_in,
	input  wire logic        ads_in,
	input  wire logic        ads_oe_n_in,
	input  wire logic        mwr_n_in,
	input  wire logic        mrd_n_in,
	input  wire logic        slow_in,
	output logic             wait_out,
	output logic             drv_out,
	output logic [15:0]      data_out
);
	logic [15:0] mem [logic [15:0]];
	logic [15:0] addr_reg = 16'h0000;
	logic        mwr_reg = 1'b1;
	assign wait_out = slow_in;
	// drive only while the read strobe is low; the bench scrambles the lines after
	assign drv_out = !mrd_n_in;
	always @(posedge clk_in) begin
		if (ads_in && !ads_oe_n_in)
			addr_reg <= bus_in;
		if (mwr_n_in && !mwr_reg)
			mem[addr_reg] = bus_in;
		mwr_reg <= mwr_n_in;
		if (mem.exists(addr_reg))
			data_out <= mem[addr_reg];
		else
			data_out <= ~data_out;
	end
endmodule // nhbi_mem_model
